// file: design/sensor_i2c_command_port.sv
// I2C target command port of a humidity and temperature sensor
//
// Function
// R01: Standard, fast, fast-plus speeds, SCL up to 1 MHz
// R02: Stretching command lets device hold SCL low
// R03: Master drives lines only low, pull-ups high
// R04: Commands form a 16-bit address space
// R05: Respond only to address 0x70
// R06: Transactions open with START, STOP optional
// R07: Wait power-up delay, then enter idle
// R08: Command 0xB098 puts device to sleep
// R09: Wake-up 0x3517 leaves sleep first
// R10: Every measurement converts temperature and humidity
// R11: Decode four normal-mode measurement codes
// R12: Decode four low-power measurement codes
// R13: Cycle: wake, measure, read, sleep, framed
// R14: Stay idle until sleep or transfer
// R15: No stretching: NACK headers while measuring
// R16: Stretching: ACK read, hold SCL, then send
// R17: Readout: two data, checksum, twice
// R18: Pins are open-drain, pull low only
// R19: Command is two bytes, MSB first, acked
`timescale 1ns/1ps
`default_nettype none
`include "sensor_i2c_defines.svh"

module sensor_i2c_command_port import sensor_i2c_pkg::*; #(
    // Power-up delay in core clock cycles, shortened in simulation
    parameter int unsigned POWER_UP_CYCLES = `POWER_UP_DELAY_US * `CLK_FREQ_MHZ
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // I2C pins, open drain
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // Sensor core
    output logic meas_start_o,
    output meas_cfg_t meas_cfg_o,
    input wire logic meas_done_i,
    input wire result_t result_i,
    // Status
    output logic ready_o,
    output logic sleep_o,
    output logic busy_o
);

    // Synchronised pins and their previous values
    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;

    // Protocol state
    i2c_state_t state_reg;
    logic [2:0] bit_cnt_reg;     // Bit within current byte
    logic byte_done_reg;         // Eighth bit sampled
    logic [7:0] rx_shift_reg;    // Received byte, MSB first
    logic [7:0] tx_shift_reg;    // Byte being sent
    logic [2:0] byte_idx_reg;    // Command or readout byte index
    logic [7:0] cmd_hi_reg;      // First command byte
    logic hdr_read_reg;          // Header asked for a read
    logic hdr_phase_reg;         // Current ack follows a header
    logic more_reg;              // Master acked last read byte and it was not the sixth

    // Power-up and sensor state
    logic [15:0] pu_cnt_reg;     // Power-up delay counter
    logic result_valid_reg;      // Completed result held
    result_t result_reg;         // Captured result words

    sync_2ff u_scl_sync (
        .clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .d_i(scl_i),
        .q_o(scl_s)
    );

    sync_2ff u_sda_sync (
        .clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .d_i(sda_i),
        .q_o(sda_s)
    );

    // Bus events; SCL is sampled well above 1 MHz, so every edge is seen
    wire scl_rise = scl_s & ~scl_d_reg;  // see R01
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;  // see R06
    wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;  // see R06

    // Header decode
    wire addr_hit = (rx_shift_reg[7:1] == `I2C_ADDR);  // see R05
    wire hdr_is_read = rx_shift_reg[0];
    wire read_ok = ~sleep_o & (busy_o ? meas_cfg_o.stretch : result_valid_reg);  // see R15
    wire hdr_ack = ready_o & addr_hit & (hdr_is_read ? read_ok : ~busy_o);  // see R15
    wire data_ack = (byte_idx_reg <= `CMD_LAST_BYTE);  // see R19

    // Command decode over the 16-bit command word
    wire [15:0] cmd_word = {cmd_hi_reg, rx_shift_reg};  // see R04
    wire cmd_is_sleep = (cmd_word == `CMD_SLEEP);  // see R08
    wire cmd_is_wake = (cmd_word == `CMD_WAKE);  // see R09
    wire m_n_st_t = (cmd_word == `CMD_MEAS_N_ST_T);  // see R11
    wire m_n_st_h = (cmd_word == `CMD_MEAS_N_ST_H);  // see R11
    wire m_n_ns_t = (cmd_word == `CMD_MEAS_N_NS_T);  // see R11
    wire m_n_ns_h = (cmd_word == `CMD_MEAS_N_NS_H);  // see R11
    wire m_l_st_t = (cmd_word == `CMD_MEAS_L_ST_T);  // see R12
    wire m_l_st_h = (cmd_word == `CMD_MEAS_L_ST_H);  // see R12
    wire m_l_ns_t = (cmd_word == `CMD_MEAS_L_NS_T);  // see R12
    wire m_l_ns_h = (cmd_word == `CMD_MEAS_L_NS_H);  // see R12
    wire cmd_is_low = m_l_st_t | m_l_st_h | m_l_ns_t | m_l_ns_h;
    wire cmd_is_meas = cmd_is_low | m_n_st_t | m_n_st_h | m_n_ns_t | m_n_ns_h;
    wire cmd_stretch = m_n_st_t | m_n_st_h | m_l_st_t | m_l_st_h;
    wire cmd_hum_first = m_n_st_h | m_n_ns_h | m_l_st_h | m_l_ns_h;
    wire cmd_last = (byte_idx_reg == `CMD_LAST_BYTE);
    wire pu_done = (pu_cnt_reg == 16'(POWER_UP_CYCLES - 1));

    // Readout byte selection
    wire [2:0] next_idx = byte_idx_reg + `BYTE_STEP;
    wire [47:0] tx_stream = meas_cfg_o.hum_first ?
        {result_reg.hum, result_reg.hum_crc, result_reg.temp, result_reg.temp_crc} :
        {result_reg.temp, result_reg.temp_crc, result_reg.hum, result_reg.hum_crc};  // see R17
    wire [7:0] tx_first = tx_stream[47:40];
    wire [7:0] tx_next = tx_stream[47 - 8 * next_idx -: 8];

    // Edge history for start, stop and SCL edges
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Power-up delay; bus is ignored until idle is reached
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pu_cnt_reg <= 16'h0000;
            ready_o <= 1'b0;
        end else if (!ready_o) begin
            pu_cnt_reg <= pu_cnt_reg + 16'h0001;
            ready_o <= pu_done;  // see R07
        end
    end

    // Pin drivers only ever pull low; enables carry the level
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;  // see R18
            sda_o <= 1'b0;  // see R18
        end
    end

    // Protocol engine, command execution and measurement bookkeeping
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= `BIT_FIRST;
            byte_done_reg <= 1'b0;
            rx_shift_reg <= 8'h00;
            tx_shift_reg <= 8'h00;
            byte_idx_reg <= `BYTE_FIRST;
            cmd_hi_reg <= 8'h00;
            hdr_read_reg <= 1'b0;
            hdr_phase_reg <= 1'b0;
            more_reg <= 1'b0;
            scl_oe_n_o <= 1'b1;
            sda_oe_n_o <= 1'b1;
            meas_start_o <= 1'b0;
            meas_cfg_o <= '0;
            sleep_o <= 1'b0;
            busy_o <= 1'b0;
            result_valid_reg <= 1'b0;
            result_reg <= '0;
        end else begin
            meas_start_o <= 1'b0;
            // Completion first, so a start in the same cycle wins
            if (meas_done_i && busy_o) begin
                busy_o <= 1'b0;
                result_valid_reg <= 1'b1;
                result_reg <= result_i;
            end
            if (!ready_o) begin
                // Held idle through the power-up delay
                state_reg <= ST_IDLE;  // see R14
            end else if (start_cond) begin
                // START or repeated START always restarts the header
                state_reg <= ST_ADDR;  // see R06
                bit_cnt_reg <= `BIT_FIRST;
                byte_done_reg <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                sda_oe_n_o <= 1'b1;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_WR: begin
                        // Sample on rising SCL, answer on the following fall
                        if (scl_rise) begin
                            rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + `BYTE_STEP;
                            byte_done_reg <= (bit_cnt_reg == `BIT_LAST);
                        end else if (scl_fall && byte_done_reg) begin
                            byte_done_reg <= 1'b0;
                            if (state_reg == ST_ADDR) begin
                                hdr_phase_reg <= 1'b1;
                                hdr_read_reg <= hdr_is_read;
                                byte_idx_reg <= `BYTE_FIRST;
                                sda_oe_n_o <= ~hdr_ack;  // see R05
                                state_reg <= hdr_ack ? ST_ACK : ST_IGNORE;  // see R15
                            end else begin
                                hdr_phase_reg <= 1'b0;
                                sda_oe_n_o <= ~data_ack;  // see R19
                                state_reg <= data_ack ? ST_ACK : ST_IGNORE;
                                byte_idx_reg <= next_idx;
                                if (byte_idx_reg == `BYTE_FIRST) begin
                                    cmd_hi_reg <= rx_shift_reg;  // see R19
                                end
                                if (cmd_last && sleep_o) begin
                                    // Asleep, only the wake-up code is obeyed
                                    sleep_o <= ~cmd_is_wake;  // see R09
                                end else if (cmd_last && cmd_is_sleep) begin
                                    sleep_o <= 1'b1;  // see R08
                                end else if (cmd_last && cmd_is_meas) begin
                                    meas_start_o <= 1'b1;  // see R10
                                    meas_cfg_o <= '{cmd_is_low, cmd_stretch, cmd_hum_first};  // see R11
                                    busy_o <= 1'b1;
                                    result_valid_reg <= 1'b0;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        // Ack bit ends on the falling SCL edge
                        if (scl_fall) begin
                            bit_cnt_reg <= `BIT_FIRST;
                            if (!hdr_phase_reg || !hdr_read_reg) begin
                                sda_oe_n_o <= 1'b1;
                                state_reg <= ST_WR;
                            end else if (busy_o) begin
                                // Hold SCL low until the result is in
                                sda_oe_n_o <= 1'b1;
                                scl_oe_n_o <= 1'b0;  // see R16
                                state_reg <= ST_STRETCH;
                            end else begin
                                tx_shift_reg <= tx_first;
                                sda_oe_n_o <= tx_first[7];
                                state_reg <= ST_RD;
                            end
                        end
                    end
                    ST_STRETCH: begin
                        // Release SCL and put the first bit on SDA in the same cycle
                        if (result_valid_reg) begin
                            scl_oe_n_o <= 1'b1;  // see R02
                            tx_shift_reg <= tx_first;
                            sda_oe_n_o <= tx_first[7];  // see R16
                            state_reg <= ST_RD;
                        end
                    end
                    ST_RD: begin
                        // Next bit goes out on each falling SCL
                        if (scl_fall) begin
                            if (bit_cnt_reg == `BIT_LAST) begin
                                sda_oe_n_o <= 1'b1;
                                state_reg <= ST_RD_ACK;
                            end else begin
                                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                                sda_oe_n_o <= tx_shift_reg[6];
                                bit_cnt_reg <= bit_cnt_reg + `BYTE_STEP;
                            end
                        end
                    end
                    ST_RD_ACK: begin
                        // Master NACK or end of six bytes stops the readout
                        if (scl_rise) begin
                            more_reg <= ~sda_s && (byte_idx_reg < `RD_LAST_BYTE);  // see R17
                            tx_shift_reg <= tx_next;
                        end else if (scl_fall) begin
                            bit_cnt_reg <= `BIT_FIRST;
                            if (more_reg) begin
                                byte_idx_reg <= next_idx;
                                sda_oe_n_o <= tx_shift_reg[7];
                                state_reg <= ST_RD;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end
                    end
                    ST_IDLE, ST_IGNORE: begin
                        // Wait for the next START
                        sda_oe_n_o <= 1'b1;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : sensor_i2c_command_port
`default_nettype wire

// file: design/sensor_i2c_defines.svh
// Constants of the sensor I2C command port: address, command codes, timing, counts
`ifndef SENSOR_I2C_DEFINES_SVH
`define SENSOR_I2C_DEFINES_SVH

// Fixed 7-bit target address
`define I2C_ADDR 7'h70

// Power state commands
`define CMD_SLEEP 16'hB098
`define CMD_WAKE 16'h3517

// Measurement commands: normal mode
`define CMD_MEAS_N_ST_T 16'h7CA2
`define CMD_MEAS_N_ST_H 16'h5C24
`define CMD_MEAS_N_NS_T 16'h7866
`define CMD_MEAS_N_NS_H 16'h58E0

// Measurement commands: low-power mode
`define CMD_MEAS_L_ST_T 16'h6458
`define CMD_MEAS_L_ST_H 16'h44DE
`define CMD_MEAS_L_NS_T 16'h609C
`define CMD_MEAS_L_NS_H 16'h401A

// Power-up delay in microseconds and core clock rate in MHz
`define POWER_UP_DELAY_US 240
`define CLK_FREQ_MHZ 50

// Bit and byte counts
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define RD_LAST_BYTE 3'h5
`define CMD_LAST_BYTE 3'h1
`define BYTE_FIRST 3'h0
`define BYTE_STEP 3'h1

`endif

// file: design/sensor_i2c_pkg.sv
// Types shared by the sensor I2C command port
package sensor_i2c_pkg;

    // Measurement options selected by a command
    typedef struct packed {
        logic low_power;  // Low-power conversion
        logic stretch;    // Clock stretching on read
        logic hum_first;  // Humidity word sent first
    } meas_cfg_t;

    // Result set from the sensor core
    typedef struct packed {
        logic [15:0] hum;
        logic [7:0] hum_crc;
        logic [15:0] temp;
        logic [7:0] temp_crc;
    } result_t;

    // Target-side protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WR,
        ST_ACK,
        ST_STRETCH,
        ST_RD,
        ST_RD_ACK,
        ST_IGNORE
    } i2c_state_t;

endpackage : sensor_i2c_pkg

// file: design/sync_2ff.sv
// Two flip-flop synchroniser for one bus pin
`timescale 1ns/1ps
`default_nettype none

module sync_2ff (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Asynchronous level in, synchronised level out
    input wire logic d_i,
    output logic q_o
);

    logic meta_reg;  // First stage, read only by the second

    // Idle bus level is high, so reset to one
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= 1'b1;
            q_o <= 1'b1;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule : sync_2ff
`default_nettype wire

// file: tb/i2c_master_model.sv
// Behavioural I2C bus master facing the command port
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
    // Wire levels of the bus
    input wire logic scl_i,
    input wire logic sda_i,
    // Pull-downs, high pulls the line low
    output logic scl_low_o,
    output logic sda_low_o
);
    localparam int Q = 40;  // Quarter of the 160 ns link period
    int extra_low = 0;  // Added SCL low time, for a slow master

    // Idle bus: both lines left to the pull-ups
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end

    // One SCL pulse carrying b; returns SDA at the rise
    task automatic clock_bit(input logic b, output logic got);
        int w;
        #(Q + extra_low);
        sda_low_o = ~b;  // Only pulls low
        #(Q);
        scl_low_o = 1'b0;
        w = 0;
        // Poll on the falling-edge grid so later pin changes stay off the sampling edge
        while (scl_i !== 1'b1 && w < 10000) begin  // Wait out a stretch
            #20;
            w++;
        end
        got = sda_i;
        #(2 * Q);
        scl_low_o = 1'b1;
    endtask : clock_bit

    // SDA falls while SCL is high
    task automatic start();
        sda_low_o = 1'b0;
        scl_low_o = 1'b0;
        #(2 * Q);
        sda_low_o = 1'b1;
        #(2 * Q);
        scl_low_o = 1'b1;
    endtask : start

    // SDA rises while SCL is high; bus left idle
    task automatic stop();
        #(Q);
        sda_low_o = 1'b1;
        #(Q);
        scl_low_o = 1'b0;
        #(2 * Q);
        sda_low_o = 1'b0;
        #(2 * Q);
    endtask : stop

    // Byte out, MSB first, then the target's acknowledge
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], g);
        clock_bit(1'b1, g);
        ack = ~g;
    endtask : wr_byte

    // Byte in; last gives a NACK that ends the readout
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, g);
            b[i] = g;
        end
        clock_bit(last, g);
    endtask : rd_byte
endmodule : i2c_master_model

`default_nettype wire

// file: tb/sensor_i2c_command_port_bench.sv
// Self-checking bench of the sensor I2C command port
`timescale 1ns/1ps
`default_nettype none
`include "sensor_i2c_defines.svh"

module sensor_i2c_command_port_bench import sensor_i2c_pkg::*; ;
    localparam int unsigned PU = 20;  // Short power-up delay
    // Clock, reset and bus
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic scl_w, sda_w, m_scl_low, m_sda_low, scl_o, scl_oe_n, sda_o, sda_oe_n;
    // Core side and status
    logic meas_start, ready, asleep, busy;
    logic meas_done = 1'b0;
    meas_cfg_t cfg;
    result_t res = '0;
    int done_wait = -1;  // Cycles until the core answers
    int n_mismatch = 0;
    int n_checks = 0;
    meas_cfg_t cfg_q[$];  // Options seen at start pulses
    logic [15:0] codes [8] = '{`CMD_MEAS_N_ST_T, `CMD_MEAS_N_ST_H, `CMD_MEAS_N_NS_T, `CMD_MEAS_N_NS_H,
        `CMD_MEAS_L_ST_T, `CMD_MEAS_L_ST_H, `CMD_MEAS_L_NS_T, `CMD_MEAS_L_NS_H};

    // Open-drain lines: low if anyone pulls, else pull-up
    assign scl_w = ~(m_scl_low | ~scl_oe_n);
    assign sda_w = ~(m_sda_low | ~sda_oe_n);

    always #10 clk = ~clk;

    sensor_i2c_command_port #(.POWER_UP_CYCLES(PU)) dut_u (
        .core_clk_i(clk), .nrst_i(nrst), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .meas_start_o(meas_start),
        .meas_cfg_o(cfg), .meas_done_i(meas_done), .result_i(res), .ready_o(ready),
        .sleep_o(asleep), .busy_o(busy));

    i2c_master_model m_u (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl_low), .sda_low_o(m_sda_low));

    // Core stand-in: random result after a random conversion time
    always @(negedge clk) begin
        // One assignment per edge: done pulses when the countdown runs out
        meas_done <= (meas_start !== 1'b1) && (busy === 1'b1) && (done_wait == 0);
        if (meas_start === 1'b1) begin
            cfg_q.push_back(cfg);
            res <= result_t'({16'($urandom), 32'($urandom)});
            done_wait <= 300 + int'($urandom_range(63));
        end else if (busy === 1'b1 && done_wait > 0) begin
            done_wait <= done_wait - 1;
        end else if (busy === 1'b1 && done_wait == 0) begin
            done_wait <= -1;
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // Whole write transfer: header, command MSB first, stop
    task automatic send_cmd(input logic [6:0] addr, input logic [15:0] code, output logic [2:0] acks);
        m_u.start();
        m_u.wr_byte({addr, 1'b0}, acks[2]);
        m_u.wr_byte(code[15:8], acks[1]);
        m_u.wr_byte(code[7:0], acks[0]);
        m_u.stop();
    endtask : send_cmd

    task automatic read_hdr(output logic ack);
        m_u.start();
        m_u.wr_byte({`I2C_ADDR, 1'b1}, ack);
    endtask : read_hdr

    // Bounded wait for the conversion to finish
    task automatic wait_idle();
        int w;
        w = 0;
        while (busy !== 1'b0 && w < 2000) begin
            @(negedge clk);
            w++;
        end
    endtask : wait_idle

    // One cycle: wake, measure, read, sleep
    task automatic measure(input int idx);
        logic [2:0] acks;
        logic ack;
        logic [7:0] b;
        logic [47:0] wd;
        meas_cfg_t ce;
        int q[$];
        int nb;
        ce = meas_cfg_t'({idx >= 4, (idx % 4) < 2, idx[0]});
        send_cmd(`I2C_ADDR, `CMD_WAKE, acks);
        check("awake", 16'h0, {15'h0, asleep});
        m_u.extra_low = (idx == 5) ? 200 : 0;
        send_cmd(`I2C_ADDR, codes[idx], acks);
        check("cmd acks", 16'h7, {13'h0, acks});
        check("starts", 16'h1, 16'(cfg_q.size()));
        check("cfg", {13'h0, ce}, {13'h0, cfg_q.pop_front()});
        read_hdr(ack);
        if (ce.stretch) begin
            check("stretch ack", 16'h1, {15'h0, ack});
            repeat (8) @(negedge clk);
            check("scl held", 16'h0, {15'h0, scl_oe_n});
        end else begin
            m_u.stop();
            check("busy read", 16'h0, {15'h0, ack});
            send_cmd(`I2C_ADDR, `CMD_WAKE, acks);
            check("busy write", 16'h0, {15'h0, acks[2]});
            wait_idle();
            read_hdr(ack);
            check("read ack", 16'h1, {15'h0, ack});
        end
        // Expected byte order follows the chosen word order
        wd = ce.hum_first ? {res.hum, res.hum_crc, res.temp, res.temp_crc}
                          : {res.temp, res.temp_crc, res.hum, res.hum_crc};
        for (int k = 0; k < 6; k++) q.push_back(int'(wd[47 - 8 * k -: 8]));
        nb = (idx == 7) ? 2 : 6;  // Early NACK on the last pass
        for (int k = 0; k < nb; k++) begin
            m_u.rd_byte(k == nb - 1, b);
            check("readout byte", 16'(q[k]), {8'h0, b});
        end
        m_u.stop();
        check("busy after read", 16'h0, {15'h0, busy});
        send_cmd(`I2C_ADDR, `CMD_SLEEP, acks);
        check("asleep again", 16'h1, {15'h0, asleep});
    endtask : measure

    // Main sequence
    initial begin
        logic [2:0] acks;
        logic ack;
        int w;
        void'($urandom(62));
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        w = 0;
        while (ready !== 1'b1 && w < 100) begin
            @(negedge clk);
            w++;
        end
        check("ready", 16'h1, {15'h0, ready});
        check("idle", 16'h0, {15'h0, asleep});
        send_cmd(7'h71, `CMD_SLEEP, acks);
        check("foreign", 16'h0, {12'h0, asleep, acks});
        send_cmd(`I2C_ADDR, `CMD_SLEEP, acks);
        check("asleep", 16'h1, {15'h0, asleep});
        read_hdr(ack);
        m_u.stop();
        check("asleep read", 16'h0, {15'h0, ack});
        send_cmd(`I2C_ADDR, codes[0], acks);
        check("asleep starts", 16'h0, 16'(cfg_q.size()));
        for (int i = 0; i < 8; i++) measure(i);
        conclude();
    end

    // Watchdog: the run needs well under a millisecond
    initial begin
        #1ms;
        n_mismatch++;
        $display("[ERR] watchdog expected finish seen hang");
        conclude();
    end
endmodule : sensor_i2c_command_port_bench

`default_nettype wire

// file: tb/sensor_i2c_command_port_sva.sv
// Pin-level assertions of the sensor I2C command port
`timescale 1ns/1ps
`default_nettype none

module sensor_i2c_command_port_chk import sensor_i2c_pkg::*; #(
    parameter int unsigned POWER_UP_CYCLES = 12000
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // I2C pins
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    // Sensor core
    input wire logic meas_start_o,
    input wire meas_cfg_t meas_cfg_o,
    input wire logic meas_done_i,
    input wire result_t result_i,
    // Status
    input wire logic ready_o,
    input wire logic sleep_o,
    input wire logic busy_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // Edges since reset release, frozen once ready
    int unsigned up_cnt_reg;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_cnt_reg <= 32'h0;
        end else if (!ready_o) begin
            up_cnt_reg <= up_cnt_reg + 32'h1;
        end
    end

    // A stretch ends with the result, then SCL is let go
    sequence stretch_end_s;
        !scl_oe_n_o && meas_done_i;
    endsequence
    sequence release_s;
        ##[1:2] scl_oe_n_o;
    endsequence

    chk_ready_delay: assert property ($rose(ready_o) |-> up_cnt_reg == POWER_UP_CYCLES)
        else $error("ready rose after the wrong count");
    chk_quiet_before_ready: assert property (!ready_o |-> sda_oe_n_o && scl_oe_n_o)
        else $error("pin driven before ready");
    chk_sda_open_drain: assert property (!sda_oe_n_o |-> !sda_o)
        else $error("sda driven high");
    chk_scl_open_drain: assert property (!scl_oe_n_o |-> !scl_o)
        else $error("scl driven high");
    chk_start_pulse: assert property (meas_start_o |-> busy_o ##1 !meas_start_o)
        else $error("start pulse malformed");
    chk_busy_drop: assert property (busy_o && meas_done_i && !meas_start_o |=> !busy_o)
        else $error("busy did not drop after done");
    chk_no_restart: assert property (meas_start_o |-> !$past(busy_o))
        else $error("start while busy");
    chk_sleep_no_start: assert property (sleep_o |-> !meas_start_o)
        else $error("start while asleep");
    chk_stretch_cfg: assert property (!scl_oe_n_o |-> meas_cfg_o.stretch && !sleep_o)
        else $error("stretch without stretching command");
    chk_stretch_busy: assert property ($fell(scl_oe_n_o) |-> $past(busy_o))
        else $error("stretch began while idle");
    chk_stretch_hold: assert property (!scl_oe_n_o && busy_o && !meas_done_i |=> !scl_oe_n_o)
        else $error("scl released before result");
    chk_stretch_release: assert property (stretch_end_s |-> release_s)
        else $error("scl held after result");
endmodule : sensor_i2c_command_port_chk

bind sensor_i2c_command_port sensor_i2c_command_port_chk #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) chk_u (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .meas_start_o(meas_start_o),
    .meas_cfg_o(meas_cfg_o), .meas_done_i(meas_done_i), .result_i(result_i),
    .ready_o(ready_o), .sleep_o(sleep_o), .busy_o(busy_o)
);

`default_nettype wire
